// file: hw/dki_pkg.sv
// package of constants and types for the drive keypad and indicator logic
package dki_pkg;

  // clock and timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int DEBOUNCE_MS   = 20;
  localparam int DEBOUNCE_CYC  = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int FLASH_MS      = 125;
  localparam int FLASH_CYC     = (CLK_HZ / 1000) * FLASH_MS;

  // key positions in the raw key vector
  localparam int KEY_LOCREM    = 0;
  localparam int KEY_MENU      = 1;
  localparam int KEY_ESC       = 2;
  localparam int KEY_JOG       = 3;
  localparam int KEY_DIR       = 4;
  localparam int KEY_SHIFT     = 5;
  localparam int KEY_INC       = 6;
  localparam int KEY_DEC       = 7;
  localparam int KEY_ENTER     = 8;
  localparam int KEY_RUN       = 9;
  localparam int KEY_STOP      = 10;
  localparam int KEY_COUNT     = 11;

  // source settings
  localparam logic [1:0] RUN_SRC_OPERATOR = 2'h0;
  localparam logic [2:0] REF_SRC_OPERATOR = 3'h0;
  localparam logic [2:0] REF_SRC_LAST     = 3'h4;

  // panel defaults
  localparam int   DIGITS_DEF   = 5;
  localparam int   ITEM_LAST_DEF = 39;
  localparam logic LOCAL_RST    = 1'b1;

  // operating modes of the panel
  typedef enum logic [4:0] {
    MODE_DRIVE    = 5'h01,
    MODE_QUICK    = 5'h02,
    MODE_ADV      = 5'h04,
    MODE_VERIFY   = 5'h08,
    MODE_AUTOTUNE = 5'h10
  } dki_mode_type;

  // displays of the panel
  typedef enum logic [2:0] {
    DISP_MODESEL = 3'h1,
    DISP_MONITOR = 3'h2,
    DISP_SETTING = 3'h4
  } dki_disp_type;

endpackage

// file: hw/dki_if.sv
// interfaces carrying key events and blink timing between the panel modules
`timescale 1ns/100ps
interface dki_key_if #(parameter int N = 11);
  logic [N-1:0] press;
  modport src (output press);
  modport dst (input press);
endinterface

interface dki_blink_if;
  logic tick;
  logic blink;
  logic flash;
  modport src (output tick, output blink, output flash);
  modport dst (input tick, input blink, input flash);
endinterface

// file: hw/dki_debounce.sv
// key debouncer turning each stable key press into a one-cycle event
`timescale 1ns/100ps
module dki_debounce #(
  parameter int N   = 11,
  parameter int CYC = 500000
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [N-1:0] raw,
  dki_key_if.src            keys
);
  import dki_pkg::*;

  localparam int             CW       = $clog2(CYC + 1);
  localparam logic [CW-1:0]  CYC_LAST = CW'(CYC - 1);

  if (CYC < 2) begin : g_chk
    $error("debounce count must be at least two cycles");
  end

  logic [N-1:0]  stable;
  logic [N-1:0]  press_q;
  logic [CW-1:0] cnt [N];

  // a level must differ from the stable one for the whole window before it counts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stable  <= '0;
      press_q <= '0;
      for (int i = 0; i < N; i++) cnt[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        press_q[i] <= 1'b0;
        if (raw[i] == stable[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] == CYC_LAST) begin
          cnt[i]     <= '0;
          stable[i]  <= raw[i];
          press_q[i] <= raw[i];
        end else begin
          cnt[i] <= cnt[i] + 1'b1;
        end
      end
    end
  end

  assign keys.press = press_q;

  AST_PRESS_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && |press_q) |=> (!ce || ((press_q & $past(press_q)) == '0)))
    else $error("key event lasted more than one cycle");
endmodule

// file: hw/dki_blink.sv
// shared slow enable pulse with flash and blink levels for the lamps
`timescale 1ns/100ps
module dki_blink #(
  parameter int CYC = 3125000
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  dki_blink_if.src  bl
);
  import dki_pkg::*;

  localparam int            CW       = $clog2(CYC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC - 1);

  if (CYC < 2) begin : g_chk
    $error("blink count must be at least two cycles");
  end

  logic [CW-1:0] cnt;
  logic          tick;
  logic          flash;
  logic          blink;

  // flash toggles on every tick, blink on every second, so blink is half as fast
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt   <= '0;
      tick  <= 1'b0;
      flash <= 1'b0;
      blink <= 1'b0;
    end else if (ce) begin
      tick <= (cnt == CYC_LAST);
      cnt  <= (cnt == CYC_LAST) ? '0 : cnt + 1'b1;
      if (tick) begin
        flash <= ~flash;
        if (flash) blink <= ~blink;
      end
    end
  end

  assign bl.tick  = tick;
  assign bl.flash = flash;
  assign bl.blink = blink;

  AST_TICK_SINGLE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && tick) |=> (!ce || !tick))
    else $error("slow enable pulse lasted more than one cycle");
endmodule

// file: hw/dki_panel.sv
// front-panel key decoding and status lamp logic of the motor drive
//
// Behaviour
// - local/remote key toggles panel/terminal control when remote switch enable allows.
// - menu key opens mode selection and then steps between operating modes.
// - escape restores display, mode and item held before the last enter.
// - jog key requests jog only under local panel control.
// - direction key toggles forward/reverse only under local panel control.
// - shift moves edit digit; with a fault active it issues fault reset.
// - increment steps mode or item forward, or raises the edited value.
// - decrement steps mode or item back, or lowers the edited value.
// - enter accepts item or value and moves to the next display.
// - run key starts the drive only under local panel control.
// - stop key stops; under terminal control only if stop key enabled.
// - forward and reverse lamps follow the forward and reverse run commands.
// - alarm lamp steady on fault, flashing on alarm only.
// - sequence lamp off in local; in remote on unless run source is 0.
// - reference lamp off in local; in remote on for reference source 1 to 4.
// - run lamp on running, blinking decelerating, off stopped.
// - stop lamp on stopped/decelerating, blinking below minimum or remote stop, else off.
// - parameter copy granted only for same software version, model, control method.
// - run accepted only on drive-mode monitor display, shown after power-up.
`timescale 1ns/100ps
module dki_panel #(
  parameter int DEBOUNCE_CYC = dki_pkg::DEBOUNCE_CYC,
  parameter int FLASH_CYC    = dki_pkg::FLASH_CYC,
  parameter int DIGITS       = dki_pkg::DIGITS_DEF,
  parameter int ITEM_LAST    = dki_pkg::ITEM_LAST_DEF,
  parameter int FREQ_W       = 16,
  parameter int ID_W         = 16
) (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            ce,
  input  wire logic [dki_pkg::KEY_COUNT-1:0]   key_raw,
  input  wire logic                            remote_switch_key_enable,
  input  wire logic                            stop_key_enable,
  input  wire logic [1:0]                      run_command_source,
  input  wire logic [2:0]                      frequency_reference_source,
  input  wire logic [FREQ_W-1:0]               freq_ref,
  input  wire logic [FREQ_W-1:0]               minimum_output_frequency,
  input  wire logic                            drive_running,
  input  wire logic                            drive_decel,
  input  wire logic                            fwd_cmd,
  input  wire logic                            rev_cmd,
  input  wire logic                            fault_active,
  input  wire logic                            alarm_active,
  input  wire logic                            copy_request,
  input  wire logic [ID_W-1:0]                 own_sw_version,
  input  wire logic [ID_W-1:0]                 peer_sw_version,
  input  wire logic [ID_W-1:0]                 own_model,
  input  wire logic [ID_W-1:0]                 peer_model,
  input  wire logic [ID_W-1:0]                 own_control_method,
  input  wire logic [ID_W-1:0]                 peer_control_method,
  output logic                                 local_mode,
  output dki_pkg::dki_mode_type                panel_mode,
  output dki_pkg::dki_disp_type                display,
  output logic [$clog2(ITEM_LAST+1)-1:0]       item_sel,
  output logic [$clog2(DIGITS)-1:0]            edit_digit,
  output logic                                 value_up,
  output logic                                 value_down,
  output logic                                 accept_pulse,
  output logic                                 jog_request,
  output logic                                 dir_reverse,
  output logic                                 fault_reset,
  output logic                                 run_request,
  output logic                                 stop_request,
  output logic                                 forward_lamp,
  output logic                                 reverse_lamp,
  output logic                                 sequence_source_lamp,
  output logic                                 reference_source_lamp,
  output logic                                 alarm_lamp,
  output logic                                 run_lamp,
  output logic                                 stop_lamp,
  output logic                                 copy_grant,
  output logic                                 copy_refuse
);
  import dki_pkg::*;

  localparam int                IW         = $clog2(ITEM_LAST + 1);
  localparam int                DW         = $clog2(DIGITS);
  localparam logic [IW-1:0]     ITEM_MAX   = IW'(ITEM_LAST);
  localparam logic [DW-1:0]     DIGIT_MAX  = DW'(DIGITS - 1);

  if (DIGITS < 2 || ITEM_LAST < 1 || FREQ_W < 1 || ID_W < 1) begin : g_chk
    $error("panel parameters out of range");
  end

  // one-hot mode rotation; autotuning is skipped while it may not be shown
  function automatic dki_mode_type mode_step(dki_mode_type m, logic up, logic hide);
    logic [4:0] r;
    r = up ? {m[3:0], m[4]} : {m[0], m[4:1]};
    if (hide && r == MODE_AUTOTUNE) r = up ? {r[3:0], r[4]} : {r[0], r[4:1]};
    return dki_mode_type'(r);
  endfunction

  // item numbers wrap from last to first and back
  function automatic logic [IW-1:0] item_step(logic [IW-1:0] i, logic up);
    logic [IW-1:0] r;
    r = '0;
    if (up) r = (i == ITEM_MAX) ? '0 : i + 1'b1;
    else    r = (i == '0) ? ITEM_MAX : i - 1'b1;
    return r;
  endfunction

  dki_key_if #(.N(KEY_COUNT)) keys ();
  dki_blink_if                bl ();

  dki_debounce #(.N(KEY_COUNT), .CYC(DEBOUNCE_CYC)) u_debounce (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .raw  (key_raw),
    .keys (keys)
  );

  dki_blink #(.CYC(FLASH_CYC)) u_blink (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .bl   (bl)
  );

  // key decode; display keys have a fixed priority menu > escape > enter > arrows
  wire logic [KEY_COUNT-1:0] p            = keys.press;
  wire logic                 menu_act     = p[KEY_MENU];
  wire logic                 esc_act      = p[KEY_ESC] && !menu_act;
  wire logic                 enter_act    = p[KEY_ENTER] && !menu_act && !esc_act;
  wire logic                 arrow_act    = (p[KEY_INC] ^ p[KEY_DEC]) && !menu_act && !esc_act
                                            && !enter_act;
  wire logic                 arrow_up     = p[KEY_INC];
  wire logic                 hide_tune    = drive_running || fault_active;
  wire logic                 drive_mon    = (display == DISP_MONITOR) && (panel_mode == MODE_DRIVE);
  wire logic                 run_ok       = p[KEY_RUN] && local_mode && drive_mon;
  wire logic                 stop_ok      = p[KEY_STOP] && (local_mode || stop_key_enable);
  wire logic                 locrem_ok    = p[KEY_LOCREM] && remote_switch_key_enable;
  wire logic                 shift_fault  = p[KEY_SHIFT] && fault_active;
  wire logic                 shift_digit  = p[KEY_SHIFT] && !fault_active && display == DISP_SETTING;
  wire logic                 ref_below    = freq_ref < minimum_output_frequency;
  wire logic                 ref_remote   = (frequency_reference_source != REF_SRC_OPERATOR)
                                            && (frequency_reference_source <= REF_SRC_LAST);
  wire logic                 copy_match   = (own_sw_version == peer_sw_version)
                                            && (own_model == peer_model)
                                            && (own_control_method == peer_control_method);

  dki_disp_type  next_display;
  dki_mode_type  next_mode;
  logic [IW-1:0] next_item;
  logic [DW-1:0] next_digit;
  dki_disp_type  snap_display;
  dki_mode_type  snap_mode;
  logic [IW-1:0] snap_item;
  logic          remote_stop_seen;

  // display walk: mode selection -> monitor -> setting -> monitor
  always_comb begin
    next_display = display;
    next_mode    = panel_mode;
    next_item    = item_sel;
    next_digit   = edit_digit;
    if (menu_act) begin
      if (display == DISP_MODESEL) next_mode = mode_step(panel_mode, 1'b1, hide_tune);
      next_display = DISP_MODESEL;
    end else if (esc_act) begin
      next_display = snap_display;
      next_mode    = snap_mode;
      next_item    = snap_item;
    end else if (enter_act) begin
      unique case (display)
        DISP_MODESEL: next_display = DISP_MONITOR;
        DISP_MONITOR: begin
          next_display = DISP_SETTING;
          next_digit   = '0;
        end
        DISP_SETTING: next_display = DISP_MONITOR;
      endcase
    end else if (arrow_act) begin
      if (display == DISP_MODESEL) next_mode = mode_step(panel_mode, arrow_up, hide_tune);
      if (display == DISP_MONITOR) next_item = item_step(item_sel, arrow_up);
    end
    if (shift_digit) next_digit = (edit_digit == DIGIT_MAX) ? '0 : edit_digit + 1'b1;
  end

  // power-up shows the drive-mode monitor display so run is possible at once
  always_ff @(posedge clk) begin
    if (!rstn) begin
      display    <= DISP_MONITOR;
      panel_mode <= MODE_DRIVE;
      item_sel   <= '0;
      edit_digit <= '0;
    end else if (ce) begin
      display    <= next_display;
      panel_mode <= next_mode;
      item_sel   <= next_item;
      edit_digit <= next_digit;
    end
  end

  // state before the latest enter, taken back by escape
  always_ff @(posedge clk) begin
    if (!rstn) begin
      snap_display <= DISP_MONITOR;
      snap_mode    <= MODE_DRIVE;
      snap_item    <= '0;
    end else if (ce && enter_act) begin
      snap_display <= display;
      snap_mode    <= panel_mode;
      snap_item    <= item_sel;
    end
  end

  // control actions; pulses last one enabled cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      local_mode   <= LOCAL_RST;
      dir_reverse  <= 1'b0;
      jog_request  <= 1'b0;
      fault_reset  <= 1'b0;
      run_request  <= 1'b0;
      stop_request <= 1'b0;
      value_up     <= 1'b0;
      value_down   <= 1'b0;
      accept_pulse <= 1'b0;
    end else if (ce) begin
      local_mode   <= local_mode ^ locrem_ok;
      dir_reverse  <= dir_reverse ^ (p[KEY_DIR] && local_mode);
      jog_request  <= p[KEY_JOG] && local_mode;
      fault_reset  <= shift_fault;
      run_request  <= run_ok;
      stop_request <= stop_ok;
      value_up     <= arrow_act && arrow_up && display == DISP_SETTING;
      value_down   <= arrow_act && !arrow_up && display == DISP_SETTING;
      accept_pulse <= enter_act;
    end
  end

  // remote stop marker: a stop pressed in the cycle the drive stops is not recorded
  always_ff @(posedge clk) begin
    if (!rstn) begin
      remote_stop_seen <= 1'b0;
    end else if (ce) begin
      remote_stop_seen <= (stop_ok && !local_mode && drive_running)
                          || (remote_stop_seen && drive_running);
    end
  end

  // lamps; deceleration takes precedence over the run condition
  always_ff @(posedge clk) begin
    if (!rstn) begin
      forward_lamp          <= 1'b0;
      reverse_lamp          <= 1'b0;
      sequence_source_lamp  <= 1'b0;
      reference_source_lamp <= 1'b0;
      alarm_lamp            <= 1'b0;
      run_lamp              <= 1'b0;
      stop_lamp             <= 1'b0;
    end else if (ce) begin
      forward_lamp          <= fwd_cmd;
      reverse_lamp          <= rev_cmd;
      sequence_source_lamp  <= !local_mode && (run_command_source != RUN_SRC_OPERATOR);
      reference_source_lamp <= !local_mode && ref_remote;
      alarm_lamp            <= fault_active || (alarm_active && bl.flash);
      run_lamp              <= drive_decel ? bl.blink : drive_running;
      stop_lamp             <= (drive_decel || !drive_running) ? 1'b1 :
                               ((ref_below || remote_stop_seen) && bl.blink);
    end
  end

  // copy is only safe between drives of the same build
  always_ff @(posedge clk) begin
    if (!rstn) begin
      copy_grant  <= 1'b0;
      copy_refuse <= 1'b0;
    end else if (ce) begin
      copy_grant  <= copy_request && copy_match;
      copy_refuse <= copy_request && !copy_match;
    end
  end

  AST_LOCREM_LOCKED: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p[KEY_LOCREM] && !remote_switch_key_enable) |=> $stable(local_mode))
    else $error("local/remote changed while key disabled");

  AST_LOCREM_TOGGLE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p[KEY_LOCREM] && remote_switch_key_enable) |=> (local_mode != $past(local_mode)))
    else $error("local/remote did not toggle");

  AST_MENU_OPENS: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p[KEY_MENU]) |=> (display == DISP_MODESEL))
    else $error("menu key did not open mode selection");

  AST_ESC_RESTORE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p == (KEY_COUNT'(1) << KEY_ENTER)) ##1 (ce && p == (KEY_COUNT'(1) << KEY_ESC))
    |=> (display == $past(display, 2)) && (item_sel == $past(item_sel, 2)))
    else $error("escape did not restore state before enter");

  AST_JOG_LOCAL: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !local_mode) |=> !jog_request)
    else $error("jog requested under terminal control");

  AST_FAULT_RESET: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p[KEY_SHIFT] && fault_active) |=> (fault_reset && $stable(edit_digit)))
    else $error("shift during fault did not reset fault");

  AST_RUN_TERMINAL: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p[KEY_RUN] && !local_mode) |=> !run_request)
    else $error("run accepted under terminal control");

  AST_RUN_DISPLAY: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p[KEY_RUN] && local_mode && display != DISP_MONITOR) |=> !run_request)
    else $error("run accepted away from drive monitor display");

  AST_STOP_REMOTE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && p[KEY_STOP]) |=> (stop_request == ($past(local_mode) || $past(stop_key_enable))))
    else $error("stop key handling wrong");

  AST_SEQ_LAMP: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> (sequence_source_lamp == ($past(!local_mode) && $past(run_command_source) != 2'h0)))
    else $error("sequence source lamp wrong");

  AST_REF_LAMP: assert property (@(posedge clk) disable iff (!rstn)
    (ce && local_mode) |=> !reference_source_lamp)
    else $error("reference source lamp lit in local mode");

  AST_ALARM_FAULT: assert property (@(posedge clk) disable iff (!rstn)
    (ce && fault_active) |=> alarm_lamp)
    else $error("alarm lamp not steady on fault");

  AST_STOP_LAMP: assert property (@(posedge clk) disable iff (!rstn)
    (ce && drive_running && !drive_decel && !ref_below && !remote_stop_seen) |=> !stop_lamp)
    else $error("stop lamp lit while running normally");

  AST_COPY_CHECK: assert property (@(posedge clk) disable iff (!rstn)
    (ce && copy_request && !copy_match) |=> (copy_refuse && !copy_grant))
    else $error("copy granted between mismatched drives");

  COV_RUN: cover property (@(posedge clk) disable iff (!rstn) run_request);
  COV_FAULT_RESET: cover property (@(posedge clk) disable iff (!rstn) fault_reset);
  COV_REMOTE_STOP_BLINK: cover property (@(posedge clk) disable iff (!rstn)
    remote_stop_seen && drive_running);
  COV_COPY_GRANT: cover property (@(posedge clk) disable iff (!rstn) copy_grant);
endmodule

// file: testbench/dki_operator.sv
// operator model that presses and releases panel keys
`timescale 1ns/100ps
module dki_operator #(
  parameter int D = 4
) (
  input  wire logic        clk,
  output logic      [10:0] key_raw
);
  // released keys read low; every edge is held past the debounce count
  initial key_raw = 11'h000;
  task automatic press(input int k);
    @(negedge clk) key_raw[k] = 1'b1;
    repeat (D + 3) @(negedge clk);
    key_raw[k] = 1'b0;
    repeat (D + 3) @(negedge clk);
  endtask
endmodule

// file: testbench/tb_dki_panel.sv
// self-checking bench for the drive keypad and indicator logic
`timescale 1ns/100ps
module tb_dki_panel;
  import dki_pkg::*;
  localparam int D = 4;
  logic clk = 0, rstn = 0, rse = 0, ske = 0, run = 0, dcl = 0, fcmd = 0, rcmd = 0;
  logic flt = 0, alm = 0, creq = 0, clr = 0;
  logic [1:0]  rcs = 2'h0;
  logic [2:0]  frs = 3'h0;
  logic [15:0] fr = 16'h0010, fmin = 16'h0008;
  logic [47:0] pid = 48'h0101_0202_0003;
  logic [10:0] key;
  logic [8:0]  p, seen;
  logic        loc, dirr, fl, rl, sl, refl, al, rnl, stl;
  dki_mode_type md;
  dki_disp_type ds;
  logic [5:0]  item;
  logic [2:0]  dig;
  int          errors = 0, n_compared = 0, cyc = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  dki_operator #(.D(D)) i_dki_operator (.clk(clk), .key_raw(key));
  dki_panel #(.DEBOUNCE_CYC(D), .FLASH_CYC(4)) i_dki_panel (
    .clk(clk), .rstn(rstn), .ce(1'b1), .key_raw(key), .remote_switch_key_enable(rse),
    .stop_key_enable(ske), .run_command_source(rcs), .frequency_reference_source(frs),
    .freq_ref(fr), .minimum_output_frequency(fmin), .drive_running(run), .drive_decel(dcl),
    .fwd_cmd(fcmd), .rev_cmd(rcmd), .fault_active(flt), .alarm_active(alm),
    .copy_request(creq), .own_sw_version(16'h0101), .peer_sw_version(pid[47:32]),
    .own_model(16'h0202), .peer_model(pid[31:16]), .own_control_method(16'h0003),
    .peer_control_method(pid[15:0]), .local_mode(loc), .panel_mode(md), .display(ds),
    .item_sel(item), .edit_digit(dig), .value_up(p[0]), .value_down(p[1]),
    .accept_pulse(p[2]), .jog_request(p[3]), .dir_reverse(dirr), .fault_reset(p[4]),
    .run_request(p[5]), .stop_request(p[6]), .forward_lamp(fl), .reverse_lamp(rl),
    .sequence_source_lamp(sl), .reference_source_lamp(refl), .alarm_lamp(al),
    .run_lamp(rnl), .stop_lamp(stl), .copy_grant(p[7]), .copy_refuse(p[8]));
  // pulses last one cycle, so they are caught in a sticky record
  always @(posedge clk) seen <= clr ? 9'h000 : (seen | p);
  // hang guard, well above the expected 570 or so cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic clear;
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
  endtask
  task automatic kp(input int k);
    clear();
    i_dki_operator.press(k);
  endtask
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask
  // lamp activity over several blink periods: {al, ~al, rnl, ~rnl, stl, ~stl} ever seen
  task automatic watch(input string nm, input logic [7:0] exp);
    logic [5:0] v;
    v = 6'h00;
    repeat (48) @(negedge clk) v |= {al, ~al, rnl, ~rnl, stl, ~stl};
    chk(nm, exp, {2'h0, v});
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    settle();
    chk("reset", 8'h81, {loc, dirr, 1'b0, md});
    chk("disp", 8'h02, ds);
    kp(KEY_INC); chk("item", 8'h01, item);
    kp(KEY_DEC); kp(KEY_DEC); chk("wrap", 8'h27, item);
    kp(KEY_ENTER); chk("enter", 8'h0c, {seen[2], ds});
    kp(KEY_SHIFT); chk("digit", 8'h01, dig);
    kp(KEY_INC); chk("up", 8'h01, seen[0]);
    kp(KEY_DEC); chk("down", 8'h02, seen[1:0]);
    kp(KEY_ESC); chk("esc", 8'h47, {ds, item[4:0]});
    kp(KEY_RUN); chk("run", 8'h01, seen[5]);
    $display("test edit done");
    kp(KEY_MENU); chk("menu", 8'h01, ds);
    kp(KEY_MENU); chk("mode", 8'h02, md);
    kp(KEY_RUN); chk("run off", 8'h00, seen[5]);
    kp(KEY_DEC); kp(KEY_ENTER); chk("back", 8'h41, {ds, md});
    kp(KEY_DIR); chk("dir", 8'h01, dirr);
    kp(KEY_JOG); chk("jog", 8'h01, seen[3]);
    flt = 1'b1;
    kp(KEY_SHIFT); chk("freset", 8'h03, {seen[4], al});
    flt = 1'b0;
    $display("test mode done");
    kp(KEY_LOCREM); chk("locked", 8'h01, loc);
    rse = 1'b1;
    kp(KEY_LOCREM); chk("remote", 8'h00, loc);
    for (int i = 0; i < KEY_COUNT; i++) if (i inside {KEY_RUN, KEY_JOG, KEY_DIR, KEY_STOP}) begin
      kp(i); chk("ignored", 8'h00, {seen[6:3], ~dirr});
    end
    ske = 1'b1;
    kp(KEY_STOP); chk("stop", 8'h01, seen[6]);
    for (int s = 0; s < 4; s++) begin
      rcs = 2'(s);
      settle(); chk("seq", {7'h00, s != 0}, sl);
    end
    for (int f = 0; f < 8; f++) begin
      frs = 3'(f);
      settle(); chk("ref", {7'h00, f inside {[1:4]}}, refl);
    end
    frs = 3'h4;
    kp(KEY_LOCREM); chk("local off", 8'h04, {loc, sl, refl});
    $display("test remote done");
    fcmd = 1'b1;
    settle(); chk("fwd", 8'h02, {fl, rl});
    {fcmd, rcmd} = 2'b01;
    settle(); chk("rev", 8'h01, {fl, rl});
    run = 1'b1;
    settle(); chk("running", 8'h02, {rnl, stl});
    run = 1'b0;
    settle(); chk("stopped", 8'h01, {rnl, stl});
    {run, dcl, alm} = 3'b111;
    watch("decel", 8'h3e);
    {dcl, alm, fr} = {2'b00, 16'h0004};
    watch("below", 8'h1b);
    $display("test lamps done");
    for (int c = 0; c < 2; c++) begin
      pid[31:16] = 16'h0202 ^ 16'(c);
      clear();
      creq = 1'b1;
      @(negedge clk) creq = 1'b0;
      settle(); chk("copy", 8'(c ? 2 : 1), seen[8:7]);
    end
    $display("test copy done");
    summarize();
  end
endmodule
